// ### design/ldf_pkg.sv
// Package: constants, phases and state record of the LED dimming and fault control
package ldf_pkg;

    // ==========================================================
    // Register map (byte addresses, word aligned)
    localparam logic [3:0] LDF_OFS_CTRL   = 4'h0;
    localparam logic [3:0] LDF_OFS_STATUS = 4'h4;
    localparam logic [3:0] LDF_OFS_CHAN   = 4'h8;
    localparam logic [3:0] LDF_OFS_PULSE  = 4'hC;
    localparam int         LDF_CTRL_EN    = 0;
    localparam logic       LDF_CTRL_RST   = 1'b0;

    // ==========================================================
    // Channel count and pulse decision threshold
    localparam int         LDF_NCH        = 4;
    localparam logic [4:0] LDF_LONG_CYC   = 5'd24;

    // ==========================================================
    // Timing: figures as printed, cycle counts derived from 100 MHz
    localparam int LDF_CLK_MHZ      = 100;
    localparam int LDF_LOW_MS       = 38;
    localparam int LDF_SS_MS        = 100;
    localparam int LDF_DET_US_X10   = 7;
    localparam int LDF_LOW_CYC      = LDF_LOW_MS * 1000 * LDF_CLK_MHZ;
    localparam int LDF_SS_CYC       = LDF_SS_MS * 1000 * LDF_CLK_MHZ;
    localparam int LDF_DET_CYC      = LDF_DET_US_X10 * 100 * LDF_CLK_MHZ;
    localparam int LDF_CNT_W        = 24;

    // ==========================================================
    // Dither generator
    localparam logic [6:0] LDF_LFSR_SEED = 7'h01;

    // ==========================================================
    // Sequencing phases
    typedef enum logic [1:0] {
        LDF_OFF    = 2'b00,
        LDF_DETECT = 2'b01,
        LDF_SSTART = 2'b10,
        LDF_RUN    = 2'b11
    } ldf_phase_e;

    // Whole state of the control block
    typedef struct packed {
        ldf_phase_e             phase;
        logic                   pwm;
        logic [4:0]             on_cnt;
        logic [4:0]             last_cnt;
        logic                   fb_min;
        logic [LDF_CNT_W-1:0]   tmr;
        logic [LDF_CNT_W-1:0]   low_tmr;
        logic [LDF_NCH-1:0]     unused;
        logic [LDF_NCH-1:0]     open_ch;
        logic [LDF_NCH-1:0]     short_ch;
        logic                   open_flt;
        logic                   uv_flt;
        logic [6:0]             lfsr;
        logic [2:0]             trim;
        logic                   enable;
        logic                   ack;
        logic [31:0]            rdata;
    } ldf_state_s;

endpackage

// ### design/ldf_control.sv
// LED dimming, feedback selection, dither and fault control with Avalon-MM registers
//
// Overview of operation
// - Brightness input gates all four sinks.
// - Short on-pulse selects overvoltage-sense feedback.
// - Long on-pulse selects minimum-sink feedback.
// - After soft-start, overvoltage feedback until long pulse.
// - Long low brightness forces overvoltage feedback.
// - Dither frequency pseudorandomly 93 to 100 percent.
// - Dither always on unless externally synchronised.
// - Fault flag low on open, short, undervoltage, thermal.
// - Thermal and short faults release automatically.
// - Open and undervoltage faults latch until enable toggles.
// - Grounded sinks marked unused before soft-start, no fault.
// - After soft-start, open strings leave minimum detector.
// - Overvoltage stops switching, gate drive forced low.
// - Overvoltage removes sinks below 300mV from detector.
// - Open detection suppressed for short pulses.
// - Shorts evaluated at each brightness rising edge.
// - Shorted strings disconnected until found removed.
// - Threshold pin at regulator disables short detection.
// - Short detection suppressed for short pulses.
// - Minimum mode: dimmed off stops switching, holds compensation.
// - Overvoltage mode: amplifier connected, converter keeps switching.
//
// ==========================================================
// Register map
// 0x0 control, read and write:
//   bit 0 enable, low clears latched faults
// 0x4 status, read only:
//   bit 0 open-string fault latched
//   bit 1 undervoltage fault latched
//   bit 2 any string shorted
//   bit 3 thermal shutdown active
//   bit 4 minimum-sink feedback selected
//   bit 5 oscillator externally synchronised
//   bits 7:6 sequencing phase
// 0x8 channels, read only:
//   bits 3:0 unused, grounded at start
//   bits 7:4 open, out of the detector
//   bits 11:8 shorted, sink disconnected
// 0xC pulse, read only:
//   bits 4:0 last on-pulse tick count
// Other offsets read zero, writes ignored
//
// ==========================================================
// Bus timing
// Every request waits exactly one cycle
// Write lands at the edge with waitrequest low
// Read data registered in the waiting cycle
// Byte lane 0 qualifies the enable write
// Back to back requests each take two cycles
//
// ==========================================================
// Sequencing
// Off: waits for enable, shared timer cleared
// Detect: collects grounded sinks for DET_CYC
// Soft-start: until done input or SS_CYC
// Run: feedback, dimming and fault handling
// Enable low returns to off from any phase
//
// ==========================================================
// Limitations
// Pulse length counts oscillator ticks only
// A pulse of 24 ticks or more counts as long
// Open and short detection need a long last pulse
// Overvoltage removal acts on any pulse length
// Thermal flag follows its input directly
// Latched faults clear only with enable low or reset
//
// ==========================================================
// Hazards
// Brightness is taken as synchronous, no synchroniser
// Sink gating is combinational so sinks follow at once
// Gate drive drops in the same cycle as overvoltage
// Enable low outranks a fault arriving in that cycle
`timescale 1ns/10ps
module ldf_control
    import ldf_pkg::*;
#(
    parameter int LOW_CYC = LDF_LOW_CYC,
    parameter int SS_CYC  = LDF_SS_CYC,
    parameter int DET_CYC = LDF_DET_CYC
) (
    input  wire logic               mclk_in,
    input  wire logic               srst_in,
    // Avalon-MM slave
    input  wire logic [3:0]         avs_address_in,
    input  wire logic               avs_read_in,
    input  wire logic               avs_write_in,
    input  wire logic [31:0]        avs_writedata_in,
    input  wire logic [3:0]         avs_byteenable_in,
    output logic      [31:0]        avs_readdata_out,
    output logic                    avs_waitrequest_out,
    // Dimming and oscillator
    input  wire logic               brightness_pwm_in,
    input  wire logic               osc_tick_in,
    input  wire logic               ext_sync_in,
    // Analog status
    input  wire logic               softstart_done_in,
    input  wire logic               overvoltage_sense_in,
    input  wire logic               undervoltage_in,
    input  wire logic               thermal_in,
    input  wire logic               short_threshold_in,
    input  wire logic [LDF_NCH-1:0] led_return_ground_in,
    input  wire logic [LDF_NCH-1:0] sink_low_in,
    input  wire logic [LDF_NCH-1:0] sink_short_in,
    // Controls to analog
    output logic      [LDF_NCH-1:0] sink_enable_out,
    output logic      [LDF_NCH-1:0] min_detect_mask_out,
    output logic                    fb_min_sink_out,
    output logic                    converter_run_out,
    output logic                    gate_drive_out,
    output logic                    erramp_connect_out,
    output logic      [2:0]         freq_trim_out,
    output logic                    fault_flag_n_out,
    output logic                    fault_flag_n_oe_out
);

    // ==========================================================
    // Helpers
    localparam logic [LDF_CNT_W-1:0] LOW_LIM = LDF_CNT_W'(LOW_CYC);
    localparam logic [LDF_CNT_W-1:0] SS_LIM  = LDF_CNT_W'(SS_CYC);
    localparam logic [LDF_CNT_W-1:0] DET_LIM = LDF_CNT_W'(DET_CYC);

    // Word select from a byte address
    function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
        hit = (addr == ofs);
    endfunction

    ldf_state_s s_q;
    ldf_state_s s_d;

    logic                   pwm_rise;
    logic                   pwm_fall;
    logic                   detect_ok;
    logic                   short_any;
    logic                   ov_now;
    logic [LDF_NCH-1:0]     active_ch;
    logic [31:0]            status_w;
    logic [31:0]            chan_w;
    logic [31:0]            rd_mux;
    logic                   req;

    // ==========================================================
    // Derived terms
    assign pwm_rise  = brightness_pwm_in & ~s_q.pwm;
    assign pwm_fall  = ~brightness_pwm_in & s_q.pwm;
    assign detect_ok = s_q.fb_min;
    assign short_any = |s_q.short_ch;
    assign active_ch = ~s_q.unused & ~s_q.short_ch;
    assign ov_now    = overvoltage_sense_in & (s_q.phase == LDF_RUN);
    assign req       = avs_read_in | avs_write_in;

    // Status word, one field per line from the top
    assign status_w = {
        24'h0,
        s_q.phase,      // Bits 7:6
        ext_sync_in,    // Bit 5
        s_q.fb_min,     // Bit 4
        thermal_in,     // Bit 3
        short_any,      // Bit 2
        s_q.uv_flt,     // Bit 1
        s_q.open_flt    // Bit 0
    };

    // Channel word: shorted, open and unused nibbles
    assign chan_w   = {
        20'h0,
        s_q.short_ch,   // Bits 11:8
        s_q.open_ch,    // Bits 7:4
        s_q.unused      // Bits 3:0
    };

    // Read data selection
    always_comb begin
        rd_mux = 32'h0;
        if (hit(avs_address_in, LDF_OFS_CTRL)) begin
            rd_mux = {31'h0, s_q.enable};
        end else if (hit(avs_address_in, LDF_OFS_STATUS)) begin
            rd_mux = status_w;
        end else if (hit(avs_address_in, LDF_OFS_CHAN)) begin
            rd_mux = chan_w;
        end else if (hit(avs_address_in, LDF_OFS_PULSE)) begin
            rd_mux = {27'h0, s_q.last_cnt};
        end
    end

    // ==========================================================
    // Next state
    always_comb begin
        s_d     = s_q;
        s_d.pwm = brightness_pwm_in;

        // Bus: one wait cycle, then answer
        // Ack toggles so a held request sees wait, then done
        // Read data captured while waiting, stands next cycle
        s_d.ack = req & ~s_q.ack;
        if (req & ~s_q.ack) begin
            s_d.rdata = avs_read_in ? rd_mux : 32'h0;
        end
        if (avs_write_in & s_q.ack & avs_byteenable_in[0] & hit(avs_address_in, LDF_OFS_CTRL)) begin
            s_d.enable = avs_writedata_in[LDF_CTRL_EN];
        end


        // Count restarts on every rise; ticks before it ignored
        // Saturation keeps long pulses from wrapping to short
        // on-pulse cycle count, saturating
        if (pwm_rise) begin
            s_d.on_cnt = 5'd0;
        end else if (brightness_pwm_in & osc_tick_in & (s_q.on_cnt < LDF_LONG_CYC)) begin
            s_d.on_cnt = s_q.on_cnt + 5'd1;
        end


        // Decision only at the fall, so a pulse in flight
        // never flips the feedback source mid-pulse
        // decide feedback at the falling edge
        if (pwm_fall) begin
            s_d.last_cnt = s_q.on_cnt;
            s_d.fb_min   = (s_q.on_cnt >= LDF_LONG_CYC);
        end


        // Low timer saturates and then holds the override
        // long low time forces overvoltage feedback
        if (brightness_pwm_in) begin
            s_d.low_tmr = '0;
        end else if (s_q.low_tmr < LOW_LIM) begin
            s_d.low_tmr = s_q.low_tmr + 1'b1;
        end else begin
            s_d.fb_min = 1'b0;
        end


        // Trim steps once per oscillator cycle only
        // Generator keeps running under sync, output is zero
        // pseudorandom trim 0..7 percent below nominal
        if (osc_tick_in) begin
            s_d.lfsr = {s_q.lfsr[5:0], s_q.lfsr[6] ^ s_q.lfsr[5]};
            s_d.trim = ext_sync_in ? 3'd0 : s_q.lfsr[2:0];
        end


        // Sequencing: off, detect, soft-start, run
        // Shared timer is reused by detect and soft-start
        unique case (s_q.phase)
            LDF_OFF: begin
                s_d.tmr = '0;
                if (s_q.enable) begin
                    s_d.phase = LDF_DETECT;
                end
            end
            LDF_DETECT: begin
                // grounded sinks are unused, no fault
                s_d.unused = s_q.unused | led_return_ground_in;
                s_d.tmr    = s_q.tmr + 1'b1;
                if (s_q.tmr >= DET_LIM) begin
                    s_d.phase = LDF_SSTART;
                    s_d.tmr   = '0;
                end
            end
            LDF_SSTART: begin
                s_d.tmr = s_q.tmr + 1'b1;
                if (undervoltage_in) begin
                    s_d.uv_flt = 1'b1;
                end
                if (softstart_done_in | (s_q.tmr >= SS_LIM)) begin
                    s_d.phase  = LDF_RUN;
                    s_d.fb_min = 1'b0;
                end
            end
            LDF_RUN: begin
                if (undervoltage_in) begin
                    s_d.uv_flt = 1'b1;
                end
                // low sinks leave detector on overvoltage
                if (ov_now) begin
                    s_d.open_ch = s_q.open_ch | (sink_low_in & ~s_q.unused);
                end
                if (ov_now & detect_ok & brightness_pwm_in & |(sink_low_in & ~s_q.unused)) begin
                    s_d.open_flt = 1'b1;
                end
                if (pwm_rise) begin
                    if (detect_ok & ~short_threshold_in) begin
                        s_d.short_ch = sink_short_in & ~s_q.unused;
                    end else if (short_threshold_in) begin
                        s_d.short_ch = '0;
                    end
                end
            end
        endcase


        // Placed last so it overrides every phase above
        // enable low clears latches and restarts
        if (~s_q.enable) begin
            s_d.phase    = LDF_OFF;
            s_d.unused   = '0;
            s_d.open_ch  = '0;
            s_d.short_ch = '0;
            s_d.open_flt = 1'b0;
            s_d.uv_flt   = 1'b0;
            s_d.fb_min   = 1'b0;
        end
    end

    // State register
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            s_q        <= '0;
            s_q.phase  <= LDF_OFF;
            s_q.lfsr   <= LDF_LFSR_SEED;
            s_q.enable <= LDF_CTRL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs
    assign avs_waitrequest_out = req & ~s_q.ack;
    assign avs_readdata_out    = s_q.rdata;


    // Sinks stay off outside run, even with brightness high
    // sinks follow brightness while running
    assign sink_enable_out     = (brightness_pwm_in && s_q.phase == LDF_RUN) ? active_ch : '0;
    assign min_detect_mask_out = active_ch & ~s_q.open_ch;
    assign fb_min_sink_out     = s_q.fb_min;
    // amplifier held off only when dimmed in minimum mode
    assign erramp_connect_out  = ~s_q.fb_min | brightness_pwm_in;

    // Switching needs soft-start or run, no overvoltage,
    // no undervoltage latch and no thermal shutdown;
    // in minimum mode it also pauses while dimmed off
    // switching permission
    assign converter_run_out   = (s_q.phase[1]) & ~overvoltage_sense_in & ~s_q.uv_flt & ~thermal_in
                                 & (~s_q.fb_min | brightness_pwm_in);
    assign gate_drive_out      = converter_run_out;
    assign freq_trim_out       = s_q.trim;

    // Pin level is always low; the enable does the signalling
    // Latched and live causes are merged here
    // open-drain fault flag, low when driven
    assign fault_flag_n_out    = 1'b0;
    assign fault_flag_n_oe_out = s_q.open_flt | s_q.uv_flt | short_any | thermal_in;

endmodule

// ### tb/ldf_control_assertions.sv
// Port checker of the LED dimming and fault control
`timescale 1ns/10ps
module ldf_control_assertions
    import ldf_pkg::*;
(
    input wire logic               mclk_in,
    input wire logic               srst_in,
    input wire logic               brightness_pwm_in,
    input wire logic               osc_tick_in,
    input wire logic               ext_sync_in,
    input wire logic               overvoltage_sense_in,
    input wire logic               thermal_in,
    input wire logic [LDF_NCH-1:0] sink_enable_out,
    input wire logic               fb_min_sink_out,
    input wire logic               converter_run_out,
    input wire logic               gate_drive_out,
    input wire logic               erramp_connect_out,
    input wire logic [2:0]         freq_trim_out,
    input wire logic               fault_flag_n_out,
    input wire logic               fault_flag_n_oe_out
);
    // ======================================
    // Properties
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (srst_in);

    sinks_follow_a: assert property ((sink_enable_out != 4'h0) |-> brightness_pwm_in || $past(brightness_pwm_in))
        else $error("sinks on while brightness low");
    ov_gate_a: assert property (overvoltage_sense_in && $past(overvoltage_sense_in) |-> !gate_drive_out && !converter_run_out)
        else $error("gate driven during overvoltage");
    thermal_flag_a: assert property (thermal_in && $past(thermal_in) |-> fault_flag_n_oe_out && !fault_flag_n_out)
        else $error("flag released during thermal fault");
    ov_amp_a: assert property (!fb_min_sink_out |-> erramp_connect_out)
        else $error("amplifier cut in overvoltage mode");
    min_hold_a: assert property (fb_min_sink_out && !brightness_pwm_in && !$past(brightness_pwm_in) |-> !converter_run_out && !erramp_connect_out)
        else $error("switching while dimmed off in minimum mode");
    sync_trim_a: assert property (osc_tick_in && ext_sync_in |=> freq_trim_out == 3'h0)
        else $error("dither active under external sync");
    trim_tick_a: assert property (!$stable(freq_trim_out) |-> $past(osc_tick_in))
        else $error("trim changed between oscillator cycles");
    fb_rise_a: assert property ($rose(fb_min_sink_out) |-> !brightness_pwm_in)
        else $error("minimum mode chosen during a pulse");
endmodule

bind ldf_control ldf_control_assertions u_ldf_control_assertions (.mclk_in, .srst_in, .brightness_pwm_in,
    .osc_tick_in, .ext_sync_in, .overvoltage_sense_in, .thermal_in, .sink_enable_out, .fb_min_sink_out,
    .converter_run_out, .gate_drive_out, .erramp_connect_out, .freq_trim_out, .fault_flag_n_out,
    .fault_flag_n_oe_out);

// ### tb/ldf_far_side.sv
// Far side model: switching oscillator and soft-start comparator
`timescale 1ns/10ps
module ldf_far_side (
    input  wire logic mclk_in,
    input  wire logic srst_in,
    input  wire logic converter_run_in,
    output logic      osc_tick_out,
    output logic      softstart_done_out
);
    logic [1:0] div_q;
    logic [4:0] ramp_q;

    // ======================================
    // Tick every fourth clock, ramp done after 20 running cycles
    always_ff @(posedge mclk_in) begin
        div_q <= srst_in ? 2'h0 : div_q + 2'h1;
        osc_tick_out <= !srst_in && (div_q == 2'h3);
        if (srst_in || !converter_run_in) begin
            ramp_q <= 5'h0;
        end else if (ramp_q != 5'd20) begin
            ramp_q <= ramp_q + 5'h1;
        end
        softstart_done_out <= (ramp_q == 5'd20);
    end
endmodule

// ### tb/tb.sv
// Testbench of the LED dimming and fault control
`timescale 1ns/10ps
module tb;
    import ldf_pkg::*;
    typedef struct packed { logic [4:0] n; logic fb; logic [4:0] cnt; } ldf_row_s;
    localparam ldf_row_s ROWS [5] = '{'{5'd5, 1'b0, 5'd5}, '{5'd23, 1'b0, 5'd23}, '{5'd24, 1'b1, 5'd24},
                                     '{5'd30, 1'b1, 5'd24}, '{5'd23, 1'b0, 5'd23}};
    logic        mclk_in = 1'b0, srst_in = 1'b1, avs_read_in = 1'b0, avs_write_in = 1'b0;
    logic        brightness_pwm_in = 1'b0, ext_sync_in = 1'b0, overvoltage_sense_in = 1'b0;
    logic        thermal_in = 1'b0, short_threshold_in = 1'b0, undervoltage_in = 1'b0;
    logic [3:0]  avs_address_in = 4'h0, led_return_ground_in = 4'h8, sink_low_in = 4'h0, sink_short_in = 4'h0;
    logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rd;
    logic [3:0]  sink_enable_out, min_detect_mask_out, se;
    logic [2:0]  freq_trim_out;
    logic        avs_waitrequest_out, osc_tick_in, softstart_done_in, fb_min_sink_out, converter_run_out;
    logic        gate_drive_out, erramp_connect_out, fault_flag_n_out, fault_flag_n_oe_out;
    int          fails = 0, cmp_count = 0;

    // ======================================
    // Design and far side
    ldf_control #(.LOW_CYC(200), .SS_CYC(300), .DET_CYC(50)) u_ldf_control (.mclk_in, .srst_in,
        .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in(4'hF),
        .avs_readdata_out, .avs_waitrequest_out, .brightness_pwm_in, .osc_tick_in, .ext_sync_in,
        .softstart_done_in, .overvoltage_sense_in, .undervoltage_in, .thermal_in, .short_threshold_in,
        .led_return_ground_in, .sink_low_in, .sink_short_in, .sink_enable_out, .min_detect_mask_out,
        .fb_min_sink_out, .converter_run_out, .gate_drive_out, .erramp_connect_out, .freq_trim_out,
        .fault_flag_n_out, .fault_flag_n_oe_out);
    ldf_far_side u_ldf_far_side (.mclk_in, .srst_in, .converter_run_in(converter_run_out),
        .osc_tick_out(osc_tick_in), .softstart_done_out(softstart_done_in));

    // Clock and watchdog
    initial forever #5 mclk_in = ~mclk_in;
    initial begin
        repeat (20000) @(posedge mclk_in);
        fails++;
        tally_and_finish();
    end

    // ======================================
    // Helpers
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Avalon cycle held until waitrequest low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        do @(posedge mclk_in); while (avs_waitrequest_out !== 1'b0);
        rd = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        @(posedge mclk_in);
    endtask
    task automatic tick;
        do @(posedge mclk_in); while (osc_tick_in !== 1'b1);
    endtask
    // Brightness pulse of n oscillator cycles
    task automatic pulse(input int n);
        tick();
        brightness_pwm_in <= 1'b1;
        repeat (n) tick();
        se = sink_enable_out;
        repeat (2) @(posedge mclk_in);
        brightness_pwm_in <= 1'b0;
        repeat (6) @(posedge mclk_in);
    endtask

    // ======================================
    // Main sequence
    initial begin
        repeat (3) @(posedge mclk_in);
        srst_in <= 1'b0;
        @(posedge mclk_in);
        bus(1'b0, LDF_OFS_STATUS, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, LDF_OFS_CTRL, 32'h1);
        repeat (150) @(posedge mclk_in);
        bus(1'b0, LDF_OFS_STATUS, 32'h0);
        chk(rd, 32'hC0);
        bus(1'b0, LDF_OFS_CHAN, 32'h0);
        chk(rd, 32'h8);
        chk(fault_flag_n_oe_out, 1'b0);
        bus(1'b0, 4'h1, 32'h0);
        chk(rd, 32'h0);
        // Pulse width table
        for (int i = 0; i < 5; i++) begin
            pulse(ROWS[i].n);
            chk(fb_min_sink_out, ROWS[i].fb);
            chk(se, 4'h7);
            chk(sink_enable_out, 4'h0);
            bus(1'b0, LDF_OFS_PULSE, 32'h0);
            chk(rd, ROWS[i].cnt);
        end
        pulse(30);
        repeat (230) @(posedge mclk_in);
        chk(fb_min_sink_out, 1'b0);
        // Shorts: suppressed, found, removed, disabled
        pulse(5);
        sink_short_in <= 4'h1;
        pulse(30);
        chk(fault_flag_n_oe_out, 1'b0);
        pulse(30);
        chk(se, 4'h6);
        chk(fault_flag_n_oe_out, 1'b1);
        sink_short_in <= 4'h0;
        pulse(30);
        chk(fault_flag_n_oe_out, 1'b0);
        short_threshold_in <= 1'b1;
        sink_short_in <= 4'h1;
        pulse(30);
        chk(fault_flag_n_oe_out, 1'b0);
        sink_short_in <= 4'h0;
        short_threshold_in <= 1'b0;
        // Thermal and sync
        thermal_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        chk(fault_flag_n_oe_out, 1'b1);
        thermal_in <= 1'b0;
        ext_sync_in <= 1'b1;
        repeat (12) @(posedge mclk_in);
        chk(fault_flag_n_oe_out, 1'b0);
        chk(freq_trim_out, 3'h0);
        ext_sync_in <= 1'b0;
        // Open string under overvoltage, cleared by enable
        pulse(30);
        tick();
        brightness_pwm_in <= 1'b1;
        sink_low_in <= 4'h2;
        overvoltage_sense_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        chk(gate_drive_out, 1'b0);
        overvoltage_sense_in <= 1'b0;
        brightness_pwm_in <= 1'b0;
        repeat (6) @(posedge mclk_in);
        chk(min_detect_mask_out, 4'h5);
        chk(fault_flag_n_oe_out, 1'b1);
        sink_low_in <= 4'h0;
        bus(1'b1, LDF_OFS_CTRL, 32'h0);
        repeat (3) @(posedge mclk_in);
        chk(fault_flag_n_oe_out, 1'b0);
        // Undervoltage latch, then a reset in mid-run
        bus(1'b1, LDF_OFS_CTRL, 32'h1);
        repeat (150) @(posedge mclk_in);
        chk(fault_flag_n_oe_out, 1'b0);
        undervoltage_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        undervoltage_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        chk(fault_flag_n_oe_out, 1'b1);
        chk(gate_drive_out, 1'b0);
        bus(1'b0, LDF_OFS_STATUS, 32'h0);
        chk(rd, 32'hC2);
        srst_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        srst_in <= 1'b0;
        @(posedge mclk_in);
        chk(fault_flag_n_oe_out, 1'b0);
        bus(1'b0, LDF_OFS_STATUS, 32'h0);
        chk(rd, 32'h0);
        tally_and_finish();
    end
endmodule
